//--- hw/dpc_ctrl_end.sv
`timescale 1ns/1ps
module dpc_ctrl_end #(
  parameter int CK_HALF = dpc_pkg::CK_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to the memory
  dpc_link_if.ctl link,
  // command request
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [dpc_pkg::BANK_W-1:0] cmd_bank,
  input wire logic [dpc_pkg::ADDR_W-1:0] cmd_addr,
  output logic cmd_ready,
  // levels sent at each falling link clock edge
  input wire logic cke_req,
  input wire logic term_req,
  // write data, one beat per take pulse
  input wire logic [dpc_pkg::DQ_W-1:0] wr_data,
  input wire logic [1:0] wr_mask,
  output logic wr_data_take,
  // read data
  output logic [dpc_pkg::DQ_W-1:0] rd_data,
  output logic rd_valid
);
  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_WRITE = 3'h2,
    C_READ = 3'h4
  } dpc_ctrl_type;

  localparam logic [3:0] HALF_LAST = 4'(CK_HALF - 1);
  localparam logic [3:0] HALF_MID = 4'(CK_HALF / 2 - 1);

  dpc_ctrl_type st_ff;
  logic [3:0] div_ff;
  logic ck_ff, tick, fall_now, bl8_ff;
  logic [3:0] bl_beats, ld_ff, tg_ff, rcv_ff;
  logic [3:0] cmd_ff;
  logic [dpc_pkg::BANK_W-1:0] bank_ff;
  logic [dpc_pkg::ADDR_W-1:0] addr_ff;
  logic cke_ff, odt_ff, str_ff, str_oe_n_ff, dq_oe_n_ff;
  logic [dpc_pkg::DQ_W-1:0] dq_ff;
  logic [1:0] mask_ff;
  logic [dpc_pkg::DQ_W:0] s;
  logic s_prev_ff;

  // link clock divided from clk; commands change on its falling edge so
  // they stand steady around the rising crossing where the memory samples
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 4'h0;
      ck_ff <= 1'b0;
    end else if (div_ff == HALF_LAST) begin
      div_ff <= 4'h0;
      ck_ff <= ~ck_ff;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end
  assign tick = div_ff == HALF_LAST;
  assign fall_now = tick & ck_ff;
  assign bl_beats = bl8_ff ? dpc_pkg::BL_BEATS_8 : dpc_pkg::BL_BEATS_4;
  assign cmd_ready = fall_now & (st_ff == C_IDLE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_ff <= dpc_pkg::CMD_DESELECT;
      bank_ff <= '0;
      addr_ff <= '0;
      cke_ff <= 1'b0;
      odt_ff <= 1'b0;
      bl8_ff <= 1'b0;
    end else if (fall_now) begin
      cke_ff <= cke_req;
      odt_ff <= term_req;
      if (cmd_ready && cmd_valid) begin
        cmd_ff <= cmd_code;
        bank_ff <= cmd_bank;
        addr_ff <= cmd_addr;
        if (cmd_code == dpc_pkg::CMD_MODE_LOAD && cmd_bank == dpc_pkg::SEL_BASE_MODE) begin
          bl8_ff <= cmd_addr[dpc_pkg::BL_LSB +: dpc_pkg::BL_W] == dpc_pkg::BL_CODE_8;
        end
      end else begin
        cmd_ff <= dpc_pkg::CMD_DESELECT;
      end
    end
  end

  dpc_sync #(.W(dpc_pkg::DQ_W + 1)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({link.lower_data_strobe, link.dq}),
    .q(s)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_prev_ff <= 1'b0;
    end else begin
      s_prev_ff <= s[dpc_pkg::DQ_W];
    end
  end

  // write strobe only inside the burst, toggled mid-beat
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= C_IDLE;
      ld_ff <= 4'h0;
      tg_ff <= 4'h0;
      rcv_ff <= 4'h0;
      str_ff <= 1'b0;
      str_oe_n_ff <= 1'b1;
      dq_oe_n_ff <= 1'b1;
      dq_ff <= '0;
      mask_ff <= 2'h0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      wr_data_take <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      wr_data_take <= 1'b0;
      case (st_ff)
        C_IDLE: begin
          if (cmd_ready && cmd_valid && cmd_code == dpc_pkg::CMD_WRITE) begin
            st_ff <= C_WRITE;
            ld_ff <= 4'h0;
            tg_ff <= 4'h0;
            str_ff <= 1'b0;
            str_oe_n_ff <= 1'b0;
          end else if (cmd_ready && cmd_valid && cmd_code == dpc_pkg::CMD_READ) begin
            st_ff <= C_READ;
            rcv_ff <= 4'h0;
          end
        end
        C_WRITE: begin
          if (tick && ld_ff < bl_beats) begin
            dq_ff <= wr_data;
            mask_ff <= wr_mask;
            dq_oe_n_ff <= 1'b0;
            wr_data_take <= 1'b1;
            ld_ff <= ld_ff + 4'h1;
          end else if (tick && tg_ff == bl_beats) begin
            st_ff <= C_IDLE;
            str_oe_n_ff <= 1'b1;
            dq_oe_n_ff <= 1'b1;
            mask_ff <= 2'h0;
            str_ff <= 1'b0;
          end else if (div_ff == HALF_MID && tg_ff < ld_ff) begin
            str_ff <= ~str_ff;
            tg_ff <= tg_ff + 4'h1;
          end
        end
        C_READ: begin
          // each strobe edge carries a beat
          if (s[dpc_pkg::DQ_W] != s_prev_ff) begin
            rd_data <= s[dpc_pkg::DQ_W-1:0];
            rd_valid <= 1'b1;
            rcv_ff <= rcv_ff + 4'h1;
            if (rcv_ff == bl_beats - 4'h1) begin
              st_ff <= C_IDLE;
            end
          end
        end
        default: st_ff <= C_IDLE;
      endcase
    end
  end

  assign link.ck = ck_ff;
  assign link.clock_comp = ~ck_ff;
  assign link.cke = cke_ff;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_ff;
  assign link.bank_select = bank_ff;
  assign link.addr = addr_ff;
  assign link.termination_enable = odt_ff;
  assign link.lower_byte_mask = mask_ff[0];
  assign link.upper_byte_mask = mask_ff[1];
  assign link.ctl_dq_o = dq_ff;
  assign link.ctl_dq_oe_n = dq_oe_n_ff;
  assign link.ctl_strobe_o = {str_ff, str_ff};
  assign link.ctl_strobe_oe_n = str_oe_n_ff;
endmodule

//--- hw/dpc_link_if.sv
`timescale 1ns/1ps
interface dpc_link_if;
  logic ck;
  logic clock_comp;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [dpc_pkg::BANK_W-1:0] bank_select;
  logic [dpc_pkg::ADDR_W-1:0] addr;
  logic termination_enable;
  logic lower_byte_mask;
  logic upper_byte_mask;
  // per-end drive of the two-way pins, enables active low
  logic [dpc_pkg::DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe_n;
  logic [dpc_pkg::DQ_W-1:0] mem_dq_o;
  logic mem_dq_oe_n;
  logic [dpc_pkg::LANES-1:0] ctl_strobe_o;
  logic ctl_strobe_oe_n;
  logic [dpc_pkg::LANES-1:0] mem_strobe_o;
  logic mem_strobe_oe_n;
  logic [dpc_pkg::LANES-1:0] mem_strobe_comp_o;
  logic mem_strobe_comp_oe_n;
  logic redundant_strobe;
  logic redundant_strobe_oe_n;
  logic redundant_strobe_comp;
  logic redundant_strobe_comp_oe_n;
  // resolved wire levels, an undriven wire reads low
  logic [dpc_pkg::DQ_W-1:0] dq;
  logic lower_data_strobe;
  logic upper_data_strobe;

  assign dq = !mem_dq_oe_n ? mem_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);
  assign lower_data_strobe = !mem_strobe_oe_n ? mem_strobe_o[0] :
                             (!ctl_strobe_oe_n ? ctl_strobe_o[0] : 1'b0);
  assign upper_data_strobe = !mem_strobe_oe_n ? mem_strobe_o[1] :
                             (!ctl_strobe_oe_n ? ctl_strobe_o[1] : 1'b0);

  modport mem (
    input ck, clock_comp, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
    input termination_enable, lower_byte_mask, upper_byte_mask,
    input dq, lower_data_strobe, upper_data_strobe,
    output mem_dq_o, mem_dq_oe_n, mem_strobe_o, mem_strobe_oe_n,
    output mem_strobe_comp_o, mem_strobe_comp_oe_n,
    output redundant_strobe, redundant_strobe_oe_n,
    output redundant_strobe_comp, redundant_strobe_comp_oe_n
  );
  modport ctl (
    output ck, clock_comp, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
    output termination_enable, lower_byte_mask, upper_byte_mask,
    output ctl_dq_o, ctl_dq_oe_n, ctl_strobe_o, ctl_strobe_oe_n,
    input dq, lower_data_strobe, upper_data_strobe
  );
endinterface

//--- hw/dpc_mem_end.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// How it works
// - row with activate, column with access
// - auto-precharge bit is flag, not column
// - precharge closes one bank or all
// - mode load writes op-code from address
// - bank lines pick bank or mode register
// - inputs sampled on rising clock crossing
// - clock-gate low stops internal clocking
// - self-refresh exit acts without clock
// - receivers off in power-down, self refresh; termination enable still sampled in power-down
// - chip select high masks all commands
// - four-bit pattern encodes the command
// - high mask discards write beat
// - lower mask low byte, upper high
// - termination follows registered enable input
// - termination input ignored when mode disables
// - read strobe edge-aligned, output on reads
// - complement strobe only in differential mode
// - redundant strobe reads only, else mask
// - redundant complement needs both enables
// - disable bit leaves complement balls unused
// - writes on both strobe edges, reads both
// - bursts of four or eight from column
module dpc_mem_end #(
  parameter int MEM_DEPTH = 1 << (dpc_pkg::BANK_W + dpc_pkg::MEM_ROW_W + dpc_pkg::MEM_COL_W)
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to the controller
  dpc_link_if.mem link,
  // status
  output logic in_power_down,
  output logic in_self_refresh,
  output logic term_active,
  output logic [3:0] bank_open,
  output logic [dpc_pkg::ADDR_W-1:0] base_mode,
  output logic [dpc_pkg::ADDR_W-1:0] ext_mode
);
  localparam int SW = 10 + dpc_pkg::BANK_W + dpc_pkg::ADDR_W + dpc_pkg::DQ_W;
  localparam int IW = dpc_pkg::BANK_W + dpc_pkg::MEM_ROW_W + dpc_pkg::MEM_COL_W;

  typedef enum logic [2:0] {
    PW_ON = 3'h1,
    PW_DOWN = 3'h2,
    PW_SREF = 3'h4
  } dpc_power_type;

  typedef enum logic [2:0] {
    BU_IDLE = 3'h1,
    BU_READ = 3'h2,
    BU_WRITE = 3'h4
  } dpc_burst_type;

  logic [SW-1:0] s;
  logic s_ck, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_odt, s_lmask, s_umask, s_lstr;
  logic [dpc_pkg::BANK_W-1:0] s_bank;
  logic [dpc_pkg::ADDR_W-1:0] s_addr;
  logic [dpc_pkg::DQ_W-1:0] s_dq;
  logic ck_prev_ff, str_prev_ff, ck_rise, ck_edge, str_edge;
  logic [3:0] cmd;
  logic cmd_ok;
  dpc_power_type pw_ff;
  dpc_burst_type bu_ff;
  logic [dpc_pkg::MEM_ROW_W-1:0] row_ff [4];
  logic [dpc_pkg::ADDR_W-1:0] ext2_mode_ff, ext3_mode_ff;
  logic [dpc_pkg::BANK_W-1:0] bu_bank_ff;
  logic [dpc_pkg::MEM_COL_W-1:0] bu_col_ff;
  logic [3:0] bu_cnt_ff;
  logic bu_ap_ff, odt_ff, bu_last, bl8, diff_en, redundant_strobe_comp_en, term_mode_en;
  logic [3:0] bl_beats;
  logic [dpc_pkg::MEM_COL_W-1:0] beat_col;
  logic [IW-1:0] beat_idx;
  logic [dpc_pkg::DQ_W-1:0] mem [MEM_DEPTH];
  logic [dpc_pkg::DQ_W-1:0] dq_ff;
  logic dq_oe_n_ff, str_ff, str_oe_n_ff;

  // every pin crosses into clk before use, the link clock included
  dpc_sync #(.W(SW)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
        link.bank_select, link.addr, link.termination_enable,
        link.lower_byte_mask, link.upper_byte_mask, link.dq, link.lower_data_strobe}),
    .q(s)
  );
  assign {s_ck, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr,
          s_odt, s_lmask, s_umask, s_dq, s_lstr} = s;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_prev_ff <= 1'b0;
      str_prev_ff <= 1'b0;
    end else begin
      ck_prev_ff <= s_ck;
      str_prev_ff <= s_lstr;
    end
  end

  assign ck_rise = s_ck & ~ck_prev_ff;
  assign ck_edge = s_ck ^ ck_prev_ff;
  assign str_edge = s_lstr ^ str_prev_ff;
  assign cmd = {s_cs_n, s_ras_n, s_cas_n, s_we_n};
  assign cmd_ok = ck_rise & s_cke & ~s_cs_n & (pw_ff == PW_ON);

  assign bl8 = base_mode[dpc_pkg::BL_LSB +: dpc_pkg::BL_W] == dpc_pkg::BL_CODE_8;
  assign bl_beats = bl8 ? dpc_pkg::BL_BEATS_8 : dpc_pkg::BL_BEATS_4;
  assign diff_en = ~ext_mode[dpc_pkg::STROBE_COMP_DISABLE_BIT];
  assign redundant_strobe_comp_en = ext_mode[dpc_pkg::REDUNDANT_EN_BIT];
  assign term_mode_en = ext_mode[dpc_pkg::TERM_EN_BIT_A] | ext_mode[dpc_pkg::TERM_EN_BIT_B];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pw_ff <= PW_ON;
    end else begin
      case (pw_ff)
        PW_ON: begin
          if (ck_rise && !s_cke) begin
            pw_ff <= (!s_cs_n && cmd == dpc_pkg::CMD_REFRESH) ? PW_SREF : PW_DOWN;
          end
        end
        PW_DOWN: begin
          if (ck_rise && s_cke) begin
            pw_ff <= PW_ON;
          end
        end
        PW_SREF: begin
          // exit needs no clock edge, the clock may be stopped
          if (s_cke) begin
            pw_ff <= PW_ON;
          end
        end
        default: pw_ff <= PW_ON;
      endcase
    end
  end
  assign in_power_down = pw_ff == PW_DOWN;
  assign in_self_refresh = pw_ff == PW_SREF;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_mode <= dpc_pkg::MODE_RESET;
      ext_mode <= dpc_pkg::MODE_RESET;
      ext2_mode_ff <= dpc_pkg::MODE_RESET;
      ext3_mode_ff <= dpc_pkg::MODE_RESET;
    end else if (cmd_ok && cmd == dpc_pkg::CMD_MODE_LOAD) begin
      case (s_bank)
        dpc_pkg::SEL_BASE_MODE: base_mode <= s_addr;
        dpc_pkg::SEL_EXT_MODE: ext_mode <= s_addr;
        dpc_pkg::SEL_EXT2_MODE: ext2_mode_ff <= s_addr;
        dpc_pkg::SEL_EXT3_MODE: ext3_mode_ff <= s_addr;
        default: base_mode <= s_addr;
      endcase
    end
  end

  // termination enable is still heard in power-down, not in self refresh
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      odt_ff <= 1'b0;
    end else if (ck_rise && pw_ff != PW_SREF) begin
      odt_ff <= s_odt;
    end
  end
  assign term_active = odt_ff & term_mode_en & (pw_ff != PW_SREF);

  assign bu_last = bu_cnt_ff == bl_beats - 4'h1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_open <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        row_ff[i] <= '0;
      end
    end else begin
      // self-timed precharge at burst end; a same-cycle activate wins
      if (bu_ap_ff && ((bu_ff == BU_READ && ck_edge && bu_cnt_ff == bl_beats) ||
                       (bu_ff == BU_WRITE && str_edge && bu_last))) begin
        bank_open[bu_bank_ff] <= 1'b0;
      end
      if (cmd_ok && cmd == dpc_pkg::CMD_ACTIVATE) begin
        bank_open[s_bank] <= 1'b1;
        row_ff[s_bank] <= s_addr[dpc_pkg::MEM_ROW_W-1:0];
      end else if (cmd_ok && cmd == dpc_pkg::CMD_PRECHARGE) begin
        if (s_addr[dpc_pkg::AUTO_PRECHARGE_BIT]) begin
          bank_open <= 4'h0;
        end else begin
          bank_open[s_bank] <= 1'b0;
        end
      end
    end
  end

  assign beat_col = bl8 ?
      {bu_col_ff[3], bu_col_ff[2:0] + bu_cnt_ff[2:0]} :
      {bu_col_ff[3:2], bu_col_ff[1:0] + bu_cnt_ff[1:0]};
  assign beat_idx = {bu_bank_ff, row_ff[bu_bank_ff], beat_col};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bu_ff <= BU_IDLE;
      bu_bank_ff <= '0;
      bu_col_ff <= '0;
      bu_cnt_ff <= 4'h0;
      bu_ap_ff <= 1'b0;
      dq_ff <= '0;
      dq_oe_n_ff <= 1'b1;
      str_ff <= 1'b0;
      str_oe_n_ff <= 1'b1;
    end else begin
      case (bu_ff)
        BU_IDLE: begin
          if (cmd_ok && (cmd == dpc_pkg::CMD_READ || cmd == dpc_pkg::CMD_WRITE) &&
              bank_open[s_bank]) begin
            bu_bank_ff <= s_bank;
            // column from bits below the flag bit
            bu_col_ff <= s_addr[dpc_pkg::MEM_COL_W-1:0];
            bu_ap_ff <= s_addr[dpc_pkg::AUTO_PRECHARGE_BIT];
            bu_cnt_ff <= 4'h0;
            if (cmd == dpc_pkg::CMD_READ) begin
              bu_ff <= BU_READ;
              // preamble: strobe driven low before the first beat
              str_ff <= 1'b0;
              str_oe_n_ff <= 1'b0;
            end else begin
              bu_ff <= BU_WRITE;
            end
          end
        end
        BU_READ: begin
          // new beat and strobe level on every clock crossing
          if (ck_edge) begin
            if (bu_cnt_ff == bl_beats) begin
              bu_ff <= BU_IDLE;
              dq_oe_n_ff <= 1'b1;
              str_oe_n_ff <= 1'b1;
              str_ff <= 1'b0;
            end else begin
              dq_ff <= mem[beat_idx];
              dq_oe_n_ff <= 1'b0;
              str_ff <= ~str_ff;
              bu_cnt_ff <= bu_cnt_ff + 4'h1;
            end
          end
        end
        BU_WRITE: begin
          if (str_edge) begin
            bu_cnt_ff <= bu_cnt_ff + 4'h1;
            if (bu_last) begin
              bu_ff <= BU_IDLE;
            end
          end
        end
        default: bu_ff <= BU_IDLE;
      endcase
    end
  end

  // byte lanes stored apart; the lower mask is ignored while
  // its ball carries the redundant strobe
  always_ff @(posedge clk) begin
    if (bu_ff == BU_WRITE && str_edge) begin
      if (!s_lmask || redundant_strobe_comp_en) begin
        mem[beat_idx][7:0] <= s_dq[7:0];
      end
      if (!s_umask) begin
        mem[beat_idx][15:8] <= s_dq[15:8];
      end
    end
  end

  assign link.mem_dq_o = dq_ff;
  assign link.mem_dq_oe_n = dq_oe_n_ff;
  assign link.mem_strobe_o = {str_ff, str_ff};
  assign link.mem_strobe_oe_n = str_oe_n_ff;
  assign link.mem_strobe_comp_o = {~str_ff, ~str_ff};
  assign link.mem_strobe_comp_oe_n = str_oe_n_ff | ~diff_en;
  // redundant strobe with read data only
  assign link.redundant_strobe = str_ff;
  assign link.redundant_strobe_oe_n = str_oe_n_ff | ~redundant_strobe_comp_en;
  assign link.redundant_strobe_comp = ~str_ff;
  assign link.redundant_strobe_comp_oe_n = str_oe_n_ff | ~redundant_strobe_comp_en | ~diff_en;
endmodule

//--- hw/dpc_pkg.sv
package dpc_pkg;
  // pin widths of the sixteen-bit configuration
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int BANK_W = 2;
  localparam int LANES = 2;

  // command pattern {chip select, row strobe, column strobe, write strobe}
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESELECT = 4'hF;

  // address field positions
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int COL_LSB_W = 10;
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [3:0] BL_BEATS_4 = 4'h4;
  localparam logic [3:0] BL_BEATS_8 = 4'h8;

  // extended mode register fields
  localparam int TERM_EN_BIT_A = 2;
  localparam int TERM_EN_BIT_B = 6;
  localparam int STROBE_COMP_DISABLE_BIT = 10;
  localparam int REDUNDANT_EN_BIT = 11;

  // mode register selected by bank_select during a mode load
  localparam logic [1:0] SEL_BASE_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT_MODE = 2'h1;
  localparam logic [1:0] SEL_EXT2_MODE = 2'h2;
  localparam logic [1:0] SEL_EXT3_MODE = 2'h3;

  localparam logic [12:0] MODE_RESET = 13'h0000;

  // stored array: bank, low row bits, low column bits
  localparam int MEM_ROW_W = 2;
  localparam int MEM_COL_W = 4;

  // link clock made by the controller from clk
  localparam int CLK_PERIOD_NS = 25;
  localparam int CK_PERIOD_NS = 200;
  localparam int CK_HALF_CYCLES = CK_PERIOD_NS / CLK_PERIOD_NS / 2;
endpackage

//--- hw/dpc_sync.sv
`timescale 1ns/1ps
module dpc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

//--- testbench/ddr2_pin_command_interface_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ddr2_pin_command_interface_tb;
  logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, cke_req = 1'b1, term_req = 1'b0;
  logic [3:0] cmd_code = 4'hF, bank_open;
  logic [1:0] cmd_bank = 2'h0, wr_mask = 2'h0;
  logic [12:0] cmd_addr = 13'h0000, base_mode, ext_mode;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic cmd_ready, wr_data_take, rd_valid, pd, sr, term;
  logic [15:0] wbuf [0:7], img [0:7];
  logic [1:0] mbuf [0:7];
  int err_count = 0, checked = 0, cyc = 0, wi = 0, ri = 0;
  dpc_link_if link();
  dpc_ctrl_end #(.CK_HALF(4)) i_dpc_ctrl_end (.clk(clk), .sys_rst(sys_rst), .link(link.ctl),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .cmd_ready(cmd_ready), .cke_req(cke_req), .term_req(term_req), .wr_data(wr_data),
    .wr_mask(wr_mask), .wr_data_take(wr_data_take), .rd_data(rd_data), .rd_valid(rd_valid));
  dpc_mem_end i_dpc_mem_end (.clk(clk), .sys_rst(sys_rst), .link(link.mem),
    .in_power_down(pd), .in_self_refresh(sr), .term_active(term), .bank_open(bank_open),
    .base_mode(base_mode), .ext_mode(ext_mode));
  dpc_link_assertions i_dpc_link_assertions (.clk(clk), .sys_rst(sys_rst), .ck(link.ck),
    .clock_comp(link.clock_comp), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .ctl_dq_oe_n(link.ctl_dq_oe_n),
    .mem_dq_oe_n(link.mem_dq_oe_n), .ctl_strobe_oe_n(link.ctl_strobe_oe_n),
    .mem_strobe_oe_n(link.mem_strobe_oe_n));
  initial forever #12.5 clk = ~clk;
  task automatic summarize();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // next beat is offered once the controller has taken the current one
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
    if (wr_data_take === 1'b1) begin
      wi <= wi + 1;
      wr_data <= wbuf[(wi + 1) % 8];
      wr_mask <= mbuf[(wi + 1) % 8];
    end
    if (rd_valid === 1'b1) begin
      `CHK(rd_data, img[ri % 8])
      ri <= ri + 1;
    end
  end
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    int n;
    n = 0;
    cmd_code <= c;
    cmd_bank <= b;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    if (cmd_ready !== 1'b1) err_count++;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [15:0] d, input logic [1:0] m, input int bl);
    for (int i = 0; i < bl; i++) begin
      wbuf[i] = d + 16'(i);
      mbuf[i] = (i == 1) ? m : 2'h0;
      if (!mbuf[i][0]) img[i][7:0] = wbuf[i][7:0];
      if (!mbuf[i][1]) img[i][15:8] = wbuf[i][15:8];
    end
    wi <= 0;
    wr_data <= wbuf[0];
    wr_mask <= mbuf[0];
    cmd(dpc_pkg::CMD_WRITE, 2'h1, a);
  endtask
  task automatic rd(input logic [12:0] a, input int bl);
    ri = 0;
    cmd(dpc_pkg::CMD_READ, 2'h1, a);
    `CHK(ri, bl)
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // clock-gate leaves reset low, so the memory sleeps until the second link rise
    repeat (16) @(posedge clk);
    cmd(dpc_pkg::CMD_MODE_LOAD, dpc_pkg::SEL_EXT_MODE, 13'h0040);
    `CHK(ext_mode, 13'h0040)
    `CHK(base_mode, 13'h0000)
    cmd(dpc_pkg::CMD_ACTIVATE, 2'h1, 13'h0002);
    `CHK(bank_open, 4'h2)
    cmd(dpc_pkg::CMD_ACTIVATE | 4'h8, 2'h0, 13'h0000);
    `CHK(bank_open, 4'h2)
    cmd(dpc_pkg::CMD_NOP, 2'h0, 13'h0000);
    `CHK(bank_open, 4'h2)
    wr(13'h0004, 16'h1200, 2'h0, 4);
    wr(13'h0004, 16'h3400, 2'h1, 4);
    rd(13'h0004, 4);
    cmd(dpc_pkg::CMD_MODE_LOAD, dpc_pkg::SEL_BASE_MODE, 13'h0003);
    wr(13'h0008, 16'h5600, 2'h0, 8);
    wr(13'h0008, 16'h7800, 2'h2, 8);
    // column bits stay clear of the flag, so the same burst comes back
    rd(13'h0408, 8);
    `CHK(bank_open, 4'h0)
    cmd(dpc_pkg::CMD_ACTIVATE, 2'h0, 13'h0001);
    cmd(dpc_pkg::CMD_ACTIVATE, 2'h1, 13'h0001);
    cmd(dpc_pkg::CMD_PRECHARGE, 2'h0, 13'h0000);
    `CHK(bank_open, 4'h2)
    cmd(dpc_pkg::CMD_PRECHARGE, 2'h3, 13'h0400);
    `CHK(bank_open, 4'h0)
    term_req <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(term, 1'b1)
    cmd(dpc_pkg::CMD_MODE_LOAD, dpc_pkg::SEL_EXT_MODE, 13'h0000);
    `CHK(term, 1'b0)
    cke_req <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK(pd, 1'b1)
    cmd(dpc_pkg::CMD_ACTIVATE, 2'h2, 13'h0000);
    `CHK(bank_open, 4'h0)
    cke_req <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(pd, 1'b0)
    cke_req <= 1'b0;
    cmd(dpc_pkg::CMD_REFRESH, 2'h0, 13'h0000);
    `CHK(sr, 1'b1)
    cke_req <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(sr, 1'b0)
    summarize();
  end
endmodule

//--- testbench/dpc_link_assertions.sv
`timescale 1ns/1ps
module dpc_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link pins
  input wire logic ck,
  input wire logic clock_comp,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic ctl_dq_oe_n,
  input wire logic mem_dq_oe_n,
  input wire logic ctl_strobe_oe_n,
  input wire logic mem_strobe_oe_n
);
  logic [3:0] pat;
  assign pat = {cs_n, ras_n, cas_n, we_n};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_sent;
    $fell(ck) && pat == dpc_pkg::CMD_READ;
  endsequence
  sequence wr_sent;
    $fell(ck) && pat == dpc_pkg::CMD_WRITE;
  endsequence
  // memory answers a read with strobe first, then data
  sequence rd_answer;
    ##[1:16] !mem_strobe_oe_n ##[0:8] !mem_dq_oe_n;
  endsequence
  a_comp_clock: assert property (clock_comp == !ck) else $error("clock pair mismatch");
  a_cmd_on_fall: assert property ($changed(pat) |-> $fell(ck)) else $error("cmd moved");
  a_cke_on_fall: assert property ($changed(cke) |-> $fell(ck)) else $error("cke moved");
  a_dq_owner: assert property (ctl_dq_oe_n || mem_dq_oe_n) else $error("dq clash");
  a_dqs_owner: assert property (ctl_strobe_oe_n || mem_strobe_oe_n) else $error("dqs clash");
  a_read_answer: assert property (rd_sent |-> rd_answer) else $error("no read data");
  a_write_strobe: assert property (wr_sent |-> !ctl_strobe_oe_n) else $error("no wr dqs");
  a_write_data: assert property (wr_sent |-> ##[1:8] !ctl_dq_oe_n) else $error("no wr dq");
endmodule
